// *** hdl/swpm_top.sv ***
`timescale 1ns/100ps
`default_nettype none
`include "swpm_defs.svh"
// Notes on behaviour
// - Software and baseband events both request power states.
// - Separate power-downs for transmit, receive, PLL, amplifier.
// - Sleep gates clocks, keeps digital core powered.
// - Sleep controller wakes on timer or host.
// - Periodic scan/sniff wakes, then sleeps again.
// - Transports idle in sleep; wake always possible.
// - Host wake during session keeps device awake.
// - Withdrawn host wake acts as sleep request.
// - Host wake output calls host for attention.
// - USB mode uses suspend/resume and remote wake.
// - Non-USB mode uses dedicated wake pins.
// - Device wake polarity programmable, default active-low.
// - Host wake polarity programmable high or low.
// - Clock request asserted while reference clock needed.
module swpm_top import swpm_pkg::*; (
  // Clock and reset; clk is the always-on low-power clock.
  input wire logic clk,
  input wire logic rst_n,
  // APB slave.
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output var logic pready,
  output var logic [31:0] prdata,
  output var logic pslverr,
  // Host wake handshake and USB suspend signalling.
  input wire logic device_wake_request,
  input wire logic usb_suspend,
  output var logic host_wake_request,
  output var logic usb_remote_wake,
  output var logic ref_clock_request,
  // Baseband core packet-handling events.
  input wire logic bb_tx_active,
  input wire logic bb_rx_active,
  input wire logic bb_busy,
  input wire logic bb_event_done,
  input wire logic bb_host_attn,
  // Power controls toward the transceiver and the chip.
  output var logic pd_tx,
  output var logic pd_rx,
  output var logic pd_pll,
  output var logic pd_pa,
  output var logic clk_gate_en,
  output var logic island_pwr_en,
  output var logic core_pwr_en,
  output var logic transport_idle,
  output var logic sleep_active,
  // Interrupt.
  output var logic irq
);

  swpm_state_t state_r;
  swpm_state_t state_nxt;
  logic [`SWPM_CTRL_W-1:0] ctrl_r;
  logic [3:0] sw_pd_r;
  logic [`SWPM_TMR_W-1:0] wake_cnt_r;
  logic [`SWPM_TMR_W-1:0] period_r;
  logic [`SWPM_TMR_W-1:0] per_cnt_r;
  logic [`SWPM_INT_W-1:0] int_stat_r;
  logic [`SWPM_INT_W-1:0] int_mask_r;
  logic [`SWPM_INT_W-1:0] int_set;
  logic [`SWPM_INT_W-1:0] rd_clr_r;
  logic [1:0] pin_sync;
  logic dev_wake_s;
  logic usb_susp_s;
  logic host_awake;
  logic host_need;
  logic tmr_expire;
  logic per_tick;
  logic [3:0] rf_use;
  logic [3:0] rf_pd_r;
  logic pready_r;
  logic pslverr_r;
  logic [31:0] prdata_r;
  logic host_wake_r;
  logic usb_rwake_r;
  logic clk_req_r;
  logic clk_gate_r;
  logic island_r;
  logic core_pwr_r;
  logic tr_idle_r;
  logic sleep_r;
  logic irq_r;
  logic wr_acc;
  logic rd_acc;

  // Decode used only by the error answer; the read mux decodes paddr in its own case.
  function automatic logic reg_mapped(input logic [7:0] a);
    reg_mapped = (a == `SWPM_OFF_CTRL) || (a == `SWPM_OFF_RFPD) || (a == `SWPM_OFF_WAKE_TIME) ||
                 (a == `SWPM_OFF_PERIOD) || (a == `SWPM_OFF_STATUS) || (a == `SWPM_OFF_INT_STAT) ||
                 (a == `SWPM_OFF_INT_MASK);
  endfunction : reg_mapped

  // The wake pins arrive from the host asynchronously, so they pass two flops first.
  swpm_sync #(.W(2)) u_pin_sync (
    .clk(clk),
    .rst_n(rst_n),
    .async_in({usb_suspend, device_wake_request}),
    .sync_out(pin_sync)
  );
  assign dev_wake_s = pin_sync[0];
  assign usb_susp_s = pin_sync[1];

  // Host demand for an awake device; a set polarity bit means active-high.
  assign host_awake = ctrl_r[`SWPM_CTRL_USB_MODE] ? !usb_susp_s :
                      (dev_wake_s == ctrl_r[`SWPM_CTRL_DEV_POL]);
  assign host_need = ctrl_r[`SWPM_CTRL_HOST_ATTN] | bb_host_attn;

  // Bus strobes at the access edge, when the slave answers.
  assign wr_acc = psel & penable & pready_r & pwrite & !pslverr_r;
  assign rd_acc = psel & penable & pready_r & !pwrite;

  // One-shot wake timer; writing zero disarms it.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      wake_cnt_r <= '0;
    end else if (wr_acc && paddr == `SWPM_OFF_WAKE_TIME) begin
      wake_cnt_r <= pwdata[`SWPM_TMR_W-1:0];
    end else if (wake_cnt_r != '0) begin
      wake_cnt_r <= wake_cnt_r - 1'b1;
    end
  end
  assign tmr_expire = (wake_cnt_r == `SWPM_TMR_W'(1));

  // Periodic scan/sniff timer, reloaded from the period register at each tick.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      per_cnt_r <= `SWPM_PERIOD_RST;
    end else if (!ctrl_r[`SWPM_CTRL_PERIODIC_EN] || per_cnt_r == '0) begin
      per_cnt_r <= period_r;
    end else begin
      per_cnt_r <= per_cnt_r - 1'b1;
    end
  end
  assign per_tick = ctrl_r[`SWPM_CTRL_PERIODIC_EN] && (per_cnt_r == '0) && (period_r != '0);

  // Sleep controller; stays clocked during sleep so a wake is seen at any time.
  always_comb begin
    state_nxt = state_r;
    case (state_r)
      ST_ACTIVE: begin
        if (ctrl_r[`SWPM_CTRL_SLEEP_EN] && !host_awake && !bb_busy && !host_need) begin
          state_nxt = ST_SLEEP;
        end
      end
      ST_SLEEP: begin
        if (host_awake || tmr_expire) begin
          state_nxt = ST_ACTIVE;
        end else if (per_tick) begin
          state_nxt = ST_EVENT;
        end
      end
      ST_EVENT: begin
        if (host_awake) begin
          state_nxt = ST_ACTIVE;
        end else if (bb_event_done) begin
          state_nxt = ST_SLEEP;
        end
      end
      default: state_nxt = ST_ACTIVE;
    endcase
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state_r <= ST_ACTIVE;
    end else begin
      state_r <= state_nxt;
    end
  end

  // Chip-level power outputs follow the next state so they line up with state_r.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      clk_gate_r <= 1'b1;
      island_r <= 1'b1;
      core_pwr_r <= 1'b1;
      tr_idle_r <= 1'b0;
      sleep_r <= 1'b0;
      clk_req_r <= 1'b1;
    end else begin
      clk_gate_r <= (state_nxt != ST_SLEEP);
      island_r <= (state_nxt != ST_SLEEP);
      core_pwr_r <= 1'b1;
      tr_idle_r <= (state_nxt != ST_ACTIVE);
      sleep_r <= (state_nxt == ST_SLEEP);
      clk_req_r <= (state_nxt != ST_SLEEP);
    end
  end

  // Baseband demand per RF path: transmit, receive, PLL, amplifier.
  assign rf_use = {bb_tx_active, bb_tx_active | bb_rx_active, bb_rx_active, bb_tx_active};

  // Each path powers down when asleep, when software forces it, or when unused.
  for (genvar i = 0; i < 4; i++) begin : g_rf_pd
    always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
        rf_pd_r[i] <= 1'b1;
      end else begin
        rf_pd_r[i] <= (state_nxt == ST_SLEEP) | sw_pd_r[i] | !rf_use[i];
      end
    end
  end

  // Host wake pin drives its asserted level only outside USB mode.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      host_wake_r <= 1'b1;
      usb_rwake_r <= 1'b0;
    end else begin
      host_wake_r <= (host_need && !ctrl_r[`SWPM_CTRL_USB_MODE]) ? ctrl_r[`SWPM_CTRL_HOST_POL] :
                     !ctrl_r[`SWPM_CTRL_HOST_POL];
      usb_rwake_r <= host_need && ctrl_r[`SWPM_CTRL_USB_MODE] && usb_susp_s;
    end
  end

  // Writable registers.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ctrl_r <= `SWPM_CTRL_RST;
      sw_pd_r <= 4'h0;
      period_r <= `SWPM_PERIOD_RST;
      int_mask_r <= '0;
    end else if (wr_acc) begin
      case (paddr)
        `SWPM_OFF_CTRL: ctrl_r <= pwdata[`SWPM_CTRL_W-1:0];
        `SWPM_OFF_RFPD: sw_pd_r <= pwdata[3:0];
        `SWPM_OFF_PERIOD: period_r <= pwdata[`SWPM_TMR_W-1:0];
        `SWPM_OFF_INT_MASK: int_mask_r <= pwdata[`SWPM_INT_W-1:0];
        default: ;
      endcase
    end
  end

  // Sticky events; a read clears only the bits it returned, and a new event wins.
  assign int_set[`SWPM_INT_TIMER] = (state_r == ST_SLEEP) && tmr_expire && !host_awake;
  assign int_set[`SWPM_INT_HOST] = (state_r != ST_ACTIVE) && host_awake;
  assign int_set[`SWPM_INT_EVENT] = (state_r == ST_SLEEP) && (state_nxt == ST_EVENT);
  assign int_set[`SWPM_INT_SLEEP] = (state_r == ST_ACTIVE) && (state_nxt == ST_SLEEP);

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      int_stat_r <= '0;
      irq_r <= 1'b0;
    end else begin
      int_stat_r <= (int_stat_r & ~((rd_acc && paddr == `SWPM_OFF_INT_STAT) ? rd_clr_r : '0)) | int_set;
      irq_r <= |(int_stat_r & int_mask_r);
    end
  end

  // APB answer: data and error captured in setup, pready high for the one access cycle.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      pready_r <= 1'b0;
      pslverr_r <= 1'b0;
      prdata_r <= '0;
      rd_clr_r <= '0;
    end else begin
      pready_r <= psel & !penable;
      if (psel && !penable) begin
        pslverr_r <= !reg_mapped(paddr);
        rd_clr_r <= int_stat_r;
        case (paddr)
          `SWPM_OFF_CTRL: prdata_r <= 32'(ctrl_r);
          `SWPM_OFF_RFPD: prdata_r <= 32'(sw_pd_r);
          `SWPM_OFF_WAKE_TIME: prdata_r <= 32'(wake_cnt_r);
          `SWPM_OFF_PERIOD: prdata_r <= 32'(period_r);
          `SWPM_OFF_STATUS: prdata_r <= 32'({rf_pd_r, host_awake, state_r});
          `SWPM_OFF_INT_STAT: prdata_r <= 32'(int_stat_r);
          `SWPM_OFF_INT_MASK: prdata_r <= 32'(int_mask_r);
          default: prdata_r <= '0;
        endcase
      end
    end
  end

  assign pready = pready_r;
  assign pslverr = pslverr_r;
  assign prdata = prdata_r;
  assign host_wake_request = host_wake_r;
  assign usb_remote_wake = usb_rwake_r;
  assign ref_clock_request = clk_req_r;
  assign pd_tx = rf_pd_r[0];
  assign pd_rx = rf_pd_r[1];
  assign pd_pll = rf_pd_r[2];
  assign pd_pa = rf_pd_r[3];
  assign clk_gate_en = clk_gate_r;
  assign island_pwr_en = island_r;
  assign core_pwr_en = core_pwr_r;
  assign transport_idle = tr_idle_r;
  assign sleep_active = sleep_r;
  assign irq = irq_r;

  // Checks on the sleep controller and its outputs.
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  sequence s_enter_sleep;
    state_r == ST_ACTIVE ##1 state_r == ST_SLEEP;
  endsequence

  sequence s_event_done;
    state_r == ST_EVENT && bb_event_done;
  endsequence

  sleep_entry_a: assert property (s_enter_sleep |-> !$past(host_awake) && $past(ctrl_r[`SWPM_CTRL_SLEEP_EN]))
    else $error("Sleep entered while host kept the device awake.");
  wake_host_a: assert property (state_r == ST_SLEEP && host_awake |=> state_r == ST_ACTIVE)
    else $error("Host wake did not wake the device.");
  wake_timer_a: assert property (state_r == ST_SLEEP && tmr_expire |=> state_r == ST_ACTIVE ##1 !tmr_expire)
    else $error("Wake timer expiry did not wake the device.");
  periodic_a: assert property (state_r == ST_SLEEP && per_tick && !host_awake && !tmr_expire
                               |=> state_r == ST_EVENT ##1 state_r != ST_ACTIVE || host_awake || $past(host_awake))
    else $error("Periodic event did not wake the device.");
  event_back_a: assert property ((s_event_done and !host_awake) |=> state_r == ST_SLEEP)
    else $error("Device did not return to sleep after the event.");
  event_stay_a: assert property (state_r == ST_EVENT && host_awake |=> state_r == ST_ACTIVE)
    else $error("Host wake during a session did not keep the device awake.");
  sleep_power_a: assert property (state_r == ST_SLEEP |-> pd_tx && pd_rx && pd_pll && pd_pa && !clk_gate_en
                                  && !island_pwr_en && core_pwr_en)
    else $error("Power controls wrong while asleep.");
  transport_a: assert property (state_r == ST_ACTIVE |-> !transport_idle)
    else $error("Transport idle while the device is active.");
  clk_req_a: assert property (s_enter_sleep |-> !ref_clock_request ##1 (state_r != ST_SLEEP || !ref_clock_request))
    else $error("Clock request held during sleep.");
  host_pol_a: assert property (!ctrl_r[`SWPM_CTRL_USB_MODE] && host_need && $stable(ctrl_r)
                               |=> host_wake_request == $past(ctrl_r[`SWPM_CTRL_HOST_POL]))
    else $error("Host wake not driven at its asserted level.");
  usb_pin_a: assert property (ctrl_r[`SWPM_CTRL_USB_MODE] && $stable(ctrl_r)
                              |=> host_wake_request == !$past(ctrl_r[`SWPM_CTRL_HOST_POL]))
    else $error("Host wake pin asserted in USB mode.");
  irq_a: assert property (|(int_stat_r & int_mask_r) |=> irq)
    else $error("Unmasked status did not raise the interrupt.");

endmodule : swpm_top

`default_nettype wire

// *** hdl/swpm_defs.svh ***
`ifndef SWPM_DEFS_SVH
`define SWPM_DEFS_SVH

// Register byte offsets on the APB.
`define SWPM_OFF_CTRL 8'h00
`define SWPM_OFF_RFPD 8'h04
`define SWPM_OFF_WAKE_TIME 8'h08
`define SWPM_OFF_PERIOD 8'h0C
`define SWPM_OFF_STATUS 8'h10
`define SWPM_OFF_INT_STAT 8'h14
`define SWPM_OFF_INT_MASK 8'h18

// Control register fields.
`define SWPM_CTRL_SLEEP_EN 0
`define SWPM_CTRL_DEV_POL 1
`define SWPM_CTRL_HOST_POL 2
`define SWPM_CTRL_USB_MODE 3
`define SWPM_CTRL_PERIODIC_EN 4
`define SWPM_CTRL_HOST_ATTN 5
`define SWPM_CTRL_W 6
`define SWPM_CTRL_RST 6'h00

// Interrupt status and mask fields.
`define SWPM_INT_TIMER 0
`define SWPM_INT_HOST 1
`define SWPM_INT_EVENT 2
`define SWPM_INT_SLEEP 3
`define SWPM_INT_W 4

// Timer widths and reset values, counted in low-power clock cycles.
`define SWPM_TMR_W 24
`define SWPM_PERIOD_RST 24'h000100

`endif

// *** hdl/swpm_pkg.sv ***
package swpm_pkg;

  // Power states of the sleep controller.
  typedef enum logic [1:0] {
    ST_ACTIVE,
    ST_SLEEP,
    ST_EVENT
  } swpm_state_t;

endpackage : swpm_pkg

// *** hdl/swpm_sync.sv ***
`timescale 1ns/100ps
`default_nettype none

module swpm_sync #(
  parameter int W = 1
) (
  // Clock and reset.
  input wire logic clk,
  input wire logic rst_n,
  // Asynchronous levels in, synchronised levels out.
  input wire logic [W-1:0] async_in,
  output var logic [W-1:0] sync_out
);

  logic [W-1:0] meta_r;

  // Two stages; only the second stage is ever read by other logic.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      meta_r <= '0;
      sync_out <= '0;
    end else begin
      meta_r <= async_in;
      sync_out <= meta_r;
    end
  end

endmodule : swpm_sync

`default_nettype wire

// *** test/swpm_host_model.sv ***
`timescale 1ns/100ps
`default_nettype none
// Host side of the wake handshake; its pins move just after a clock edge.
module swpm_host_model (
  // Clock and reset.
  input wire logic clk,
  input wire logic rst_n,
  // Bench commands and the polarities programmed into the device.
  input wire logic want_awake,
  input wire logic suspend,
  input wire logic dev_pol,
  input wire logic host_pol,
  // Wake pins.
  input wire logic host_wake_request,
  output var logic device_wake_request,
  output var logic usb_suspend,
  output var logic host_awake
);
  // Dropping the wake level is how this host asks the device to sleep.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      device_wake_request <= 1'h1;
      usb_suspend <= 1'h0;
    end else begin
      device_wake_request <= want_awake ? dev_pol : !dev_pol;
      usb_suspend <= suspend;
    end
  end
  // The host stays awake only while the device holds its wake output asserted.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      host_awake <= 1'h1;
    end else begin
      host_awake <= (host_wake_request == host_pol);
    end
  end
endmodule : swpm_host_model
`default_nettype wire

// *** test/test_sleep_wake_power_manager.sv ***
`timescale 1ns/100ps
`default_nettype none
`include "swpm_defs.svh"
module test_sleep_wake_power_manager import swpm_pkg::*;;
  typedef struct {logic [7:0] a; logic [31:0] d; logic [31:0] q; logic e;} swpm_row_t;
  logic clk, rst_n, psel, penable, pwrite, pready, pslverr, e, bad;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, q;
  logic device_wake_request, usb_suspend, host_wake_request, usb_remote_wake, ref_clock_request;
  logic bb_tx_active, bb_rx_active, bb_busy, bb_event_done, bb_host_attn;
  logic pd_tx, pd_rx, pd_pll, pd_pa, clk_gate_en, island_pwr_en, core_pwr_en, transport_idle, sleep_active, irq;
  logic want_awake, suspend, dp, hp, host_awake;
  int num_errors, num_checks, n;
  // Register rows: address, write data, expected read back, expected error.
  swpm_row_t rows [6] = '{'{`SWPM_OFF_STATUS, 32'h0, 32'h7C, 1'h0}, '{`SWPM_OFF_RFPD, 32'hF, 32'hF, 1'h0},
    '{`SWPM_OFF_PERIOD, 32'h1234, 32'h1234, 1'h0}, '{`SWPM_OFF_INT_MASK, 32'hFFFFFFFF, 32'hF, 1'h0},
    '{`SWPM_OFF_WAKE_TIME, 32'h0, 32'h0, 1'h0}, '{8'h1C, 32'h5A, 32'h0, 1'h1}};

  swpm_top dut_u (.clk, .rst_n, .psel, .penable, .pwrite, .paddr, .pwdata, .pready, .prdata, .pslverr,
    .device_wake_request, .usb_suspend, .host_wake_request, .usb_remote_wake, .ref_clock_request,
    .bb_tx_active, .bb_rx_active, .bb_busy, .bb_event_done, .bb_host_attn, .pd_tx, .pd_rx, .pd_pll,
    .pd_pa, .clk_gate_en, .island_pwr_en, .core_pwr_en, .transport_idle, .sleep_active, .irq);
  swpm_host_model host_u (.clk, .rst_n, .want_awake, .suspend, .dev_pol(dp), .host_pol(hp),
    .host_wake_request, .device_wake_request, .usb_suspend, .host_awake);

  // Free-running clock, 50 ns period.
  initial begin
    clk = 1'h0;
    forever #25 clk = ~clk;
  end

  task automatic chk(input logic [31:0] g, input logic [31:0] x);
    num_checks++;
    if (g !== x) begin
      num_errors++;
      $display("MISMATCH at %0t: got %h expected %h", $time, g, x);
    end
  endtask : chk

  // One APB transfer; waits for pready however long it takes, within a bound.
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int k;
    k = 0;
    psel <= 1'h1;
    penable <= 1'h0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'h1;
    do begin
      @(posedge clk);
      k++;
    end while (pready !== 1'h1 && k < 64);
    if (k >= 64) num_errors++;
    q = prdata;
    e = pslverr;
    psel <= 1'h0;
    penable <= 1'h0;
    @(posedge clk);
  endtask : apb

  task automatic wait_sleep(input logic v);
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (sleep_active !== v && n < 300);
    if (n >= 300) num_errors++;
  endtask : wait_sleep

  task automatic done(input string s);
    $display("Test %s finished", s);
  endtask : done

  task automatic end_sim;
    $display("Checks %0d, mismatches %0d", num_checks, num_errors);
    if (num_errors == 0 && num_checks > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : end_sim

  // A hang is cut short well beyond the few hundred cycles the tests need.
  initial begin
    repeat (20000) @(posedge clk);
    num_errors++;
    end_sim();
  end

  initial begin
    {rst_n, psel, penable, pwrite, suspend, dp, hp, bb_busy, bb_event_done, bb_host_attn} = '0;
    {bb_tx_active, bb_rx_active} = '0;
    paddr = '0;
    pwdata = '0;
    want_awake = 1'h1;
    repeat (12) @(posedge clk);
    rst_n <= 1'h1;
    @(posedge clk);
    chk(32'({host_wake_request, usb_remote_wake, ref_clock_request, core_pwr_en, sleep_active, irq,
      pd_tx, pd_rx, pd_pll, pd_pa}), 32'h2CF);
    apb(1'h0, `SWPM_OFF_CTRL, 32'h0);
    chk(q, 32'h0);
    apb(1'h0, `SWPM_OFF_PERIOD, 32'h0);
    chk(q, `SWPM_PERIOD_RST);
    done("reset");
    foreach (rows[i]) begin
      apb(1'h1, rows[i].a, rows[i].d);
      chk(32'(e), 32'(rows[i].e));
      apb(1'h0, rows[i].a, 32'h0);
      chk(q, rows[i].q);
      chk(32'(e), 32'(rows[i].e));
    end
    done("registers");
    // Software force-down first overrides the baseband, then each path follows its own cause.
    bb_tx_active <= 1'h1;
    bb_rx_active <= 1'h1;
    repeat (2) @(posedge clk);
    chk(32'({pd_tx, pd_rx, pd_pll, pd_pa}), 32'hF);
    apb(1'h1, `SWPM_OFF_RFPD, 32'h0);
    // The power-downs are registered one edge after the write lands, so let that edge pass.
    @(posedge clk);
    chk(32'({pd_tx, pd_rx, pd_pll, pd_pa}), 32'h0);
    bb_rx_active <= 1'h0;
    repeat (2) @(posedge clk);
    chk(32'({pd_tx, pd_rx, pd_pll, pd_pa}), 32'h4);
    bb_tx_active <= 1'h0;
    bb_rx_active <= 1'h1;
    repeat (2) @(posedge clk);
    chk(32'({pd_tx, pd_rx, pd_pll, pd_pa}), 32'h9);
    bb_rx_active <= 1'h0;
    done("rf");
    apb(1'h1, `SWPM_OFF_CTRL, 32'h1);
    bb_busy <= 1'h1;
    want_awake <= 1'h0;
    repeat (10) @(posedge clk);
    chk(32'(sleep_active), 32'h0);
    bb_busy <= 1'h0;
    wait_sleep(1'h1);
    chk(n, 2);
    chk(32'({clk_gate_en, island_pwr_en, core_pwr_en, transport_idle, ref_clock_request,
      pd_tx, pd_rx, pd_pll, pd_pa}), 32'h6F);
    repeat (2) @(posedge clk);
    chk(32'(irq), 32'h1);
    apb(1'h0, `SWPM_OFF_INT_STAT, 32'h0);
    chk(q & 32'h8, 32'h8);
    repeat (2) @(posedge clk);
    chk(32'(irq), 32'h0);
    done("sleep");
    // Timer wake with the interrupt masked off.
    apb(1'h1, `SWPM_OFF_INT_MASK, 32'h0);
    apb(1'h1, `SWPM_OFF_WAKE_TIME, 32'h14);
    wait_sleep(1'h0);
    chk(32'(n >= 15 && n <= 22), 32'h1);
    repeat (2) @(posedge clk);
    chk(32'(irq), 32'h0);
    apb(1'h0, `SWPM_OFF_INT_STAT, 32'h0);
    chk(q & 32'h1, 32'h1);
    apb(1'h1, `SWPM_OFF_INT_MASK, 32'hF);
    done("timer");
    want_awake <= 1'h1;
    wait_sleep(1'h0);
    chk(32'(n >= 4 && n <= 6), 32'h1);
    chk(32'({transport_idle, ref_clock_request}), 32'h1);
    repeat (2) @(posedge clk);
    chk(32'(irq), 32'h1);
    apb(1'h0, `SWPM_OFF_INT_STAT, 32'h0);
    chk(q & 32'h2, 32'h2);
    done("host wake");
    // Periodic events from sleep, then a host wake in mid-session keeps it awake.
    apb(1'h1, `SWPM_OFF_PERIOD, 32'hA);
    apb(1'h1, `SWPM_OFF_CTRL, 32'h11);
    want_awake <= 1'h0;
    wait_sleep(1'h1);
    wait_sleep(1'h0);
    chk(32'({transport_idle, clk_gate_en, n <= 12}), 32'h7);
    bb_event_done <= 1'h1;
    wait_sleep(1'h1);
    bb_event_done <= 1'h0;
    chk(32'(n <= 3), 32'h1);
    wait_sleep(1'h0);
    want_awake <= 1'h1;
    repeat (8) @(posedge clk);
    bad = 1'h0;
    repeat (40) begin
      @(posedge clk);
      bad |= transport_idle | sleep_active;
    end
    chk(32'({bad, clk_gate_en}), 32'h1);
    apb(1'h1, `SWPM_OFF_CTRL, 32'h0);
    done("periodic");
    chk(32'({host_wake_request, host_awake}), 32'h2);
    apb(1'h1, `SWPM_OFF_CTRL, 32'h20);
    repeat (3) @(posedge clk);
    chk(32'({host_wake_request, host_awake}), 32'h1);
    hp <= 1'h1;
    apb(1'h1, `SWPM_OFF_CTRL, 32'h24);
    repeat (3) @(posedge clk);
    chk(32'({host_wake_request, host_awake}), 32'h3);
    apb(1'h1, `SWPM_OFF_CTRL, 32'h4);
    bb_host_attn <= 1'h1;
    repeat (3) @(posedge clk);
    chk(32'({host_wake_request, host_awake}), 32'h3);
    bb_host_attn <= 1'h0;
    repeat (3) @(posedge clk);
    chk(32'(host_wake_request), 32'h0);
    apb(1'h1, `SWPM_OFF_CTRL, 32'h2C);
    suspend <= 1'h1;
    repeat (5) @(posedge clk);
    chk(32'({usb_remote_wake, host_wake_request}), 32'h2);
    suspend <= 1'h0;
    repeat (5) @(posedge clk);
    chk(32'(usb_remote_wake), 32'h0);
    apb(1'h1, `SWPM_OFF_CTRL, 32'h0);
    hp <= 1'h0;
    done("host output");
    // Active-high wake: the pin settles before the polarity write so no sleep slips in.
    dp <= 1'h1;
    repeat (4) @(posedge clk);
    apb(1'h1, `SWPM_OFF_CTRL, 32'h3);
    repeat (6) @(posedge clk);
    chk(32'(sleep_active), 32'h0);
    want_awake <= 1'h0;
    wait_sleep(1'h1);
    chk(32'(n <= 6), 32'h1);
    done("polarity");
    rst_n <= 1'h0;
    repeat (2) @(posedge clk);
    chk(32'({host_wake_request, sleep_active, ref_clock_request}), 32'h5);
    dp <= 1'h0;
    want_awake <= 1'h1;
    rst_n <= 1'h1;
    @(posedge clk);
    apb(1'h0, `SWPM_OFF_CTRL, 32'h0);
    chk(q, 32'h0);
    done("second reset");
    end_sim();
  end
endmodule : test_sleep_wake_power_manager
`default_nettype wire
